/* rtl/cra_pkg.sv */
// Constants and types for the processor register set and address generator
package cra_pkg;

  // ---------------------------------------------------------------------
  // Clock and machine cycle
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 25;
  localparam int unsigned CYCLE_PERIOD_NS  = 25;
  localparam int unsigned CLKS_PER_CYCLE   = (CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Register indices on the plain register port
  // ---------------------------------------------------------------------
  localparam logic [2:0] REG_PROGRAM_COUNTER = 3'h0;
  localparam logic [2:0] REG_STACK_POINTER   = 3'h1;
  localparam logic [2:0] REG_INDEX_REGISTER  = 3'h2;
  localparam logic [2:0] REG_ACCUMULATOR_A   = 3'h3;
  localparam logic [2:0] REG_ACCUMULATOR_B   = 3'h4;
  localparam logic [2:0] REG_CONDITION_CODE  = 3'h5;
  localparam logic [2:0] REG_CYCLE_COUNT     = 3'h6;

  // ---------------------------------------------------------------------
  // Condition code field positions and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned CC_CARRY     = 0;
  localparam int unsigned CC_OVERFLOW  = 1;
  localparam int unsigned CC_ZERO      = 2;
  localparam int unsigned CC_NEGATIVE  = 3;
  localparam int unsigned CC_IRQ_MASK  = 4;
  localparam int unsigned CC_HALF      = 5;
  localparam logic [1:0]  CC_TOP_ONES  = 2'h3;
  localparam logic [5:0]  CC_RESET     = 6'h10;
  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [7:0]  DIRECT_PAGE  = 8'h00;

  // ---------------------------------------------------------------------
  // Opcode groups and instruction lengths
  // ---------------------------------------------------------------------
  localparam int unsigned  INSTR_TYPES   = 72;
  localparam logic [7:0]   OP_LOAD_SP_IMM = 8'h8E;
  localparam logic [7:0]   OP_LOAD_X_IMM  = 8'hCE;
  localparam logic [1:0]   LEN_ONE   = 2'h1;
  localparam logic [1:0]   LEN_TWO   = 2'h2;
  localparam logic [1:0]   LEN_THREE = 2'h3;
  localparam logic [15:0]  REL_BIAS  = 16'h0002;
  localparam logic [15:0]  IMM_BIAS  = 16'h0001;

  // Addressing modes, one-hot
  typedef enum logic [6:0] {
    MODE_ACCUMULATOR = 7'h01,
    MODE_IMMEDIATE   = 7'h02,
    MODE_DIRECT      = 7'h04,
    MODE_EXTENDED    = 7'h08,
    MODE_INDEXED     = 7'h10,
    MODE_IMPLIED     = 7'h20,
    MODE_RELATIVE    = 7'h40
  } cra_mode_e;

  // ALU operations
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_ADC = 3'h1,
    ALU_SUB = 3'h2,
    ALU_SBC = 3'h3,
    ALU_AND = 3'h4,
    ALU_OR  = 3'h5,
    ALU_EOR = 3'h6,
    ALU_LD  = 3'h7
  } cra_alu_e;

endpackage : cra_pkg

/* rtl/cra_alu8.sv */
// Eight-bit arithmetic logic unit with result flags
`timescale 1ns/1ps
module cra_alu8
  import cra_pkg::*;
(
  // Operation and operands
  input  wire cra_alu_e   op,
  input  wire logic [7:0] a,
  input  wire logic [7:0] m,
  input  wire logic       cin,
  // Result and flags
  output logic [7:0]      res,
  output logic            neg,
  output logic            zero,
  output logic            ovf,
  output logic            carry,
  output logic            half
);

  logic [8:0] sum9;
  logic [4:0] low5;
  logic       cy;

  // Carry in only for the with-carry forms
  assign cy = cin & ((op == ALU_ADC) | (op == ALU_SBC));

  // Result, carry out of bit 7, half carry out of bit 3
  always_comb begin
    sum9 = 9'h000;
    low5 = 5'h00;
    res  = a;
    ovf  = 1'b0;
    unique case (op)
      ALU_ADD, ALU_ADC: begin
        sum9 = {1'b0, a} + {1'b0, m} + {8'h00, cy};
        low5 = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cy};
        res  = sum9[7:0];
        ovf  = (a[7] == m[7]) & (res[7] != a[7]);
      end
      ALU_SUB, ALU_SBC: begin
        sum9 = {1'b0, a} - {1'b0, m} - {8'h00, cy};
        res  = sum9[7:0];
        ovf  = (a[7] != m[7]) & (res[7] != a[7]);
      end
      ALU_AND: res = a & m;
      ALU_OR:  res = a | m;
      ALU_EOR: res = a ^ m;
      ALU_LD:  res = m;
    endcase
  end

  assign carry = sum9[8];
  assign half  = low5[4];
  assign neg   = res[7];
  assign zero  = (res == 8'h00);

endmodule : cra_alu8

/* rtl/cra_core.sv */
// Programmer register set, addressing-mode decoder and address generator
`timescale 1ns/1ps
// Overview of operation
// - Sixteen-bit program counter holds the address of the current instruction.
// - Sixteen-bit stack pointer addresses the next free stack location.
// - Sixteen-bit index register holds data or an indexed base address.
// - Two eight-bit accumulators feed the ALU and take its results.
// - Each ALU operation records negative, zero and overflow; carry only for arithmetic ops, half carry only for add ops.
// - Condition code bit 4 is the interrupt mask.
// - Condition code bits 6 and 7 always read as one.
// - Decoder classifies all 72 instruction types by opcode group.
// - Accumulator mode picks A or B; instruction is one byte.
// - Immediate operand is byte two; stack and index loads use bytes two-three.
// - Direct mode address is byte two, page zero; two bytes long.
// - Extended address is byte two high, byte three low; three bytes.
// - Indexed address is index low plus byte two, carry into high.
// - Indexed sum sits in a temporary register; index unchanged; two bytes.
// - Implied mode names its register by opcode; one byte long.
// - Relative target is counter plus two plus signed byte two.
// - Execution time counts machine cycles of one clock each.
// - Maskable interrupt is taken only while the mask flag is clear.
module cra_core
  import cra_pkg::*;
#(
  parameter int unsigned CYC_W = 32
)(
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             srst,
  // Register port
  input  wire logic [2:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [15:0]           reg_rdata,
  // Instruction decode request
  input  wire logic             dec_valid,
  input  wire logic [7:0]       dec_opcode,
  input  wire logic [7:0]       dec_byte2,
  input  wire logic [7:0]       dec_byte3,
  input  wire logic             pc_advance,
  // Decode answer
  output logic                  dec_done,
  output cra_mode_e             dec_mode,
  output logic [1:0]            dec_len,
  output logic [15:0]           dec_ea,
  output logic                  dec_acc_b,
  // ALU request
  input  wire logic             alu_valid,
  input  wire cra_alu_e         alu_op,
  input  wire logic             alu_sel_b,
  input  wire logic [7:0]       alu_operand,
  // Stack access
  input  wire logic             stk_push,
  input  wire logic             stk_pull,
  output logic [15:0]           stk_addr,
  // Interrupt request
  input  wire logic             irq_req,
  input  wire logic             instr_end,
  output logic                  irq_take,
  output logic [7:0]            ccr_out
);

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [15:0]      program_counter_reg;
  logic [15:0]      stack_pointer_reg;
  logic [15:0]      index_register_reg;
  logic [7:0]       accumulator_a_reg;
  logic [7:0]       accumulator_b_reg;
  logic [5:0]       ccr_reg;
  logic [CYC_W-1:0] cycle_reg;
  cra_mode_e        mode_next;
  logic [1:0]       len_next;
  logic [15:0]      ea_next;
  logic [7:0]       alu_src;
  logic [7:0]       alu_res;
  logic             f_n;
  logic             f_z;
  logic             f_v;
  logic             f_c;
  logic             f_h;
  logic             alu_arith;
  logic [7:0]       ccr_full;
  logic             bus_wr_pc;
  logic             bus_wr_sp;
  logic             bus_wr_x;
  logic             bus_wr_a;
  logic             bus_wr_b;
  logic             bus_wr_cc;

  assign ccr_full  = {CC_TOP_ONES, ccr_reg};
  assign bus_wr_pc = reg_wr & (reg_addr == REG_PROGRAM_COUNTER);
  assign bus_wr_sp = reg_wr & (reg_addr == REG_STACK_POINTER);
  assign bus_wr_x  = reg_wr & (reg_addr == REG_INDEX_REGISTER);
  assign bus_wr_a  = reg_wr & (reg_addr == REG_ACCUMULATOR_A);
  assign bus_wr_b  = reg_wr & (reg_addr == REG_ACCUMULATOR_B);
  assign bus_wr_cc = reg_wr & (reg_addr == REG_CONDITION_CODE);

  // ---------------------------------------------------------------------
  // Addressing-mode decoder
  // ---------------------------------------------------------------------
  // Opcode groups by high nibble cover every instruction type
  always_comb begin
    mode_next = MODE_IMPLIED;
    len_next  = LEN_ONE;
    ea_next   = WORD_RESET;
    unique case (dec_opcode[7:4])
      4'h2: begin
        mode_next = MODE_RELATIVE;
        len_next  = LEN_TWO;
        ea_next   = program_counter_reg + REL_BIAS + {{8{dec_byte2[7]}}, dec_byte2};
      end
      4'h4, 4'h5: begin
        mode_next = MODE_ACCUMULATOR;
        len_next  = LEN_ONE;
      end
      4'h6, 4'hA, 4'hE: begin
        mode_next = MODE_INDEXED;
        len_next  = LEN_TWO;
        ea_next   = index_register_reg + {8'h00, dec_byte2};
      end
      4'h7, 4'hB, 4'hF: begin
        mode_next = MODE_EXTENDED;
        len_next  = LEN_THREE;
        ea_next   = {dec_byte2, dec_byte3};
      end
      4'h8, 4'hC: begin
        mode_next = MODE_IMMEDIATE;
        ea_next   = program_counter_reg + IMM_BIAS;
        if ((dec_opcode == OP_LOAD_SP_IMM) || (dec_opcode == OP_LOAD_X_IMM)) begin
          len_next = LEN_THREE;
        end else begin
          len_next = LEN_TWO;
        end
      end
      4'h9, 4'hD: begin
        mode_next = MODE_DIRECT;
        len_next  = LEN_TWO;
        ea_next   = {DIRECT_PAGE, dec_byte2};
      end
      default: begin
        mode_next = MODE_IMPLIED;
        len_next  = LEN_ONE;
      end
    endcase
  end

  // Decode answer; the sum lands in its own temporary address register
  always_ff @(posedge clock) begin
    if (srst) begin
      dec_done  <= 1'b0;
      dec_mode  <= MODE_IMPLIED;
      dec_len   <= LEN_ONE;
      dec_ea    <= WORD_RESET;
      dec_acc_b <= 1'b0;
    end else begin
      dec_done <= dec_valid;
      if (dec_valid) begin
        dec_mode  <= mode_next;
        dec_len   <= len_next;
        dec_ea    <= ea_next;
        // Accumulator-only opcodes pick B by bit 4, memory opcodes by bit 6
        if (mode_next == MODE_ACCUMULATOR) begin
          dec_acc_b <= dec_opcode[4];
        end else begin
          dec_acc_b <= dec_opcode[6];
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Program counter, index register
  // ---------------------------------------------------------------------
  // Counter holds the current instruction until told to step past it
  always_ff @(posedge clock) begin
    if (srst) begin
      program_counter_reg <= WORD_RESET;
    end else if (bus_wr_pc) begin
      program_counter_reg <= reg_wdata;
    end else if (pc_advance) begin
      program_counter_reg <= program_counter_reg + {14'h0000, dec_len};
    end
  end

  // Index register changes only by software write
  always_ff @(posedge clock) begin
    if (srst) begin
      index_register_reg <= WORD_RESET;
    end else if (bus_wr_x) begin
      index_register_reg <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------------
  // Push uses the free slot then moves down; pull moves up then uses it
  always_ff @(posedge clock) begin
    if (srst) begin
      stack_pointer_reg <= WORD_RESET;
      stk_addr          <= WORD_RESET;
    end else begin
      if (stk_push && !stk_pull) begin
        stk_addr <= stack_pointer_reg;
      end else if (stk_pull && !stk_push) begin
        stk_addr <= stack_pointer_reg + 16'h0001;
      end
      if (bus_wr_sp) begin
        stack_pointer_reg <= reg_wdata;
      end else if (stk_push && !stk_pull) begin
        stack_pointer_reg <= stack_pointer_reg - 16'h0001;
      end else if (stk_pull && !stk_push) begin
        stack_pointer_reg <= stack_pointer_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Accumulators and ALU
  // ---------------------------------------------------------------------
  assign alu_src   = alu_sel_b ? accumulator_b_reg : accumulator_a_reg;
  assign alu_arith = (alu_op == ALU_ADD) | (alu_op == ALU_ADC)
                   | (alu_op == ALU_SUB) | (alu_op == ALU_SBC);

  cra_alu8 u_alu (
    .op    (alu_op),
    .a     (alu_src),
    .m     (alu_operand),
    .cin   (ccr_reg[CC_CARRY]),
    .res   (alu_res),
    .neg   (f_n),
    .zero  (f_z),
    .ovf   (f_v),
    .carry (f_c),
    .half  (f_h)
  );

  // Result goes back to the selected accumulator
  always_ff @(posedge clock) begin
    if (srst) begin
      accumulator_a_reg <= BYTE_RESET;
      accumulator_b_reg <= BYTE_RESET;
    end else begin
      if (bus_wr_a) begin
        accumulator_a_reg <= reg_wdata[7:0];
      end else if (alu_valid && !alu_sel_b) begin
        accumulator_a_reg <= alu_res;
      end
      if (bus_wr_b) begin
        accumulator_b_reg <= reg_wdata[7:0];
      end else if (alu_valid && alu_sel_b) begin
        accumulator_b_reg <= alu_res;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Condition codes and interrupt acceptance
  // ---------------------------------------------------------------------
  // Logic ops clear V and leave C and H; interrupt entry sets the mask
  always_ff @(posedge clock) begin
    if (srst) begin
      ccr_reg  <= CC_RESET;
      irq_take <= 1'b0;
    end else begin
      irq_take <= instr_end & irq_req & ~ccr_reg[CC_IRQ_MASK];
      if (bus_wr_cc) begin
        ccr_reg <= reg_wdata[5:0];
      end else begin
        if (alu_valid) begin
          ccr_reg[CC_NEGATIVE] <= f_n;
          ccr_reg[CC_ZERO]     <= f_z;
          ccr_reg[CC_OVERFLOW] <= alu_arith & f_v;
          if (alu_arith) begin
            ccr_reg[CC_CARRY] <= f_c;
          end
          if ((alu_op == ALU_ADD) || (alu_op == ALU_ADC)) begin
            ccr_reg[CC_HALF] <= f_h;
          end
        end
      end
      // Mask set beats a same-cycle write, so a taken request never leaves it open
      if (instr_end && irq_req && !ccr_reg[CC_IRQ_MASK]) begin
        ccr_reg[CC_IRQ_MASK] <= 1'b1;
      end
    end
  end

  // Flags as seen by branch logic outside
  always_ff @(posedge clock) begin
    if (srst) begin
      ccr_out <= {CC_TOP_ONES, CC_RESET};
    end else begin
      ccr_out <= ccr_full;
    end
  end

  // ---------------------------------------------------------------------
  // Machine cycle counter and register read
  // ---------------------------------------------------------------------
  // One machine cycle per clock; wraps silently, software takes deltas
  always_ff @(posedge clock) begin
    if (srst) begin
      cycle_reg <= '0;
    end else begin
      cycle_reg <= cycle_reg + CYC_W'(CLKS_PER_CYCLE);
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= WORD_RESET;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_PROGRAM_COUNTER: reg_rdata <= program_counter_reg;
        REG_STACK_POINTER:   reg_rdata <= stack_pointer_reg;
        REG_INDEX_REGISTER:  reg_rdata <= index_register_reg;
        REG_ACCUMULATOR_A:   reg_rdata <= {8'h00, accumulator_a_reg};
        REG_ACCUMULATOR_B:   reg_rdata <= {8'h00, accumulator_b_reg};
        REG_CONDITION_CODE:  reg_rdata <= {8'h00, ccr_full};
        REG_CYCLE_COUNT:     reg_rdata <= cycle_reg[15:0];
        default:             reg_rdata <= WORD_RESET;
      endcase
    end else begin
      reg_rdata <= WORD_RESET;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_ccr_top;
    reg_rd && (reg_addr == REG_CONDITION_CODE) |=> reg_rdata[7:6] == CC_TOP_ONES;
  endproperty
  a_ccr_top: assert property (p_ccr_top)
    else $error("condition code top bits not one");

  property p_direct;
    dec_valid && ((dec_opcode[7:4] == 4'h9) || (dec_opcode[7:4] == 4'hD))
      |=> dec_ea == {DIRECT_PAGE, $past(dec_byte2)} && dec_len == LEN_TWO;
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address or length wrong");

  property p_extended;
    dec_valid && (dec_opcode[7:4] == 4'hB)
      |=> dec_ea == {$past(dec_byte2), $past(dec_byte3)} && dec_len == LEN_THREE;
  endproperty
  a_extended: assert property (p_extended)
    else $error("extended address or length wrong");

  property p_indexed;
    dec_valid && (dec_opcode[7:4] == 4'hA) && !reg_wr
      |=> dec_ea == index_register_reg + {8'h00, $past(dec_byte2)} && $stable(index_register_reg);
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong or index moved");

  property p_relative;
    dec_valid && (dec_opcode[7:4] == 4'h2) && !reg_wr && !pc_advance
      |=> dec_ea == program_counter_reg + REL_BIAS + {{8{$past(dec_byte2[7])}}, $past(dec_byte2)};
  endproperty
  a_relative: assert property (p_relative)
    else $error("relative target wrong");

  property p_imm_wide;
    dec_valid && ((dec_opcode == OP_LOAD_SP_IMM) || (dec_opcode == OP_LOAD_X_IMM))
      |=> dec_mode == MODE_IMMEDIATE && dec_len == LEN_THREE;
  endproperty
  a_imm_wide: assert property (p_imm_wide)
    else $error("wide immediate length wrong");

  property p_acc_mode;
    dec_valid && (dec_opcode[7:5] == 3'h2)
      |=> dec_mode == MODE_ACCUMULATOR && dec_len == LEN_ONE && dec_acc_b == $past(dec_opcode[4]);
  endproperty
  a_acc_mode: assert property (p_acc_mode)
    else $error("accumulator mode decode wrong");

  property p_push;
    stk_push && !stk_pull && !bus_wr_sp
      |=> stack_pointer_reg == $past(stack_pointer_reg) - 16'h0001 && stk_addr == $past(stack_pointer_reg);
  endproperty
  a_push: assert property (p_push)
    else $error("push did not use then decrement");

  property p_irq;
    instr_end && irq_req && !bus_wr_cc
      |=> irq_take == !$past(ccr_reg[CC_IRQ_MASK]) && ccr_reg[CC_IRQ_MASK];
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt taken against mask");

  property p_cycles;
    1'b1 |-> ##2 cycle_reg == $past(cycle_reg, 2) + CYC_W'(2);
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("cycle counter not one per clock");

endmodule : cra_core

/* testbench/cra_mem_model.sv */
// Behavioural program memory feeding instruction bytes to the decoder
`timescale 1ns/1ps
module cra_mem_model (
  // Fetch address
  input  wire logic [15:0] addr,
  // Bytes at addr, addr+1 and addr+2
  output logic [7:0]       byte0,
  output logic [7:0]       byte1,
  output logic [7:0]       byte2
);
  // Program: idx, ext, dir, imm word load, acc, implied, rel, idx
  localparam logic [127:0] PROG = 128'hA605_B612_3496_808E_1234_4F01_2080_E6FF;

  // Unwritten space gives the low address byte XOR 5A, so stale bytes never look valid
  function automatic logic [7:0] fetch(input logic [15:0] a);
    if (a[15:4] != 12'h000) return a[7:0] ^ 8'h5A;
    return PROG[(15 - a[3:0]) * 8 +: 8];
  endfunction : fetch

  // Combinational read ports
  assign byte0 = fetch(addr);
  assign byte1 = fetch(addr + 16'h0001);
  assign byte2 = fetch(addr + 16'h0002);
endmodule : cra_mem_model

/* testbench/cra_core_bench.sv */
// Self-checking bench for the register set and address generator
`timescale 1ns/1ps
module cra_core_bench
  import cra_pkg::*;
;
  // ---------------------------------------------------------------
  // Stimulus, expectations and instances
  // ---------------------------------------------------------------
  localparam int TIMEOUT_CYCLES = 2000;
  localparam logic [6:0]  EXP_MODE [8] = '{7'h10, 7'h08, 7'h04, 7'h02, 7'h01, 7'h20, 7'h40, 7'h10};
  localparam logic [1:0]  EXP_LEN  [8] = '{2'h2, 2'h3, 2'h2, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2};
  localparam logic [15:0] EXP_EA   [8] = '{16'h1104, 16'h1234, 16'h0080, 16'h0008,
                                          16'h0000, 16'h0000, 16'hFF8E, 16'h11FE};
  localparam logic        EXP_ACCB [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, dec_valid = 1'b0, pc_advance = 1'b0;
  logic [7:0]  dec_opcode = 8'h00, dec_byte2 = 8'h00, dec_byte3 = 8'h00, alu_operand = 8'h00;
  logic        alu_valid = 1'b0, alu_sel_b = 1'b0, stk_push = 1'b0, stk_pull = 1'b0;
  logic        irq_req = 1'b0, instr_end = 1'b0;
  cra_alu_e    alu_op = ALU_ADD;
  logic [15:0] reg_rdata, dec_ea, stk_addr, rv, cnt0, pc = 16'h0000;
  logic [7:0]  ccr_out, mb0, mb1, mb2;
  logic [1:0]  dec_len;
  logic        dec_done, dec_acc_b, irq_take;
  cra_mode_e   dec_mode;
  int          err_count = 0, num_checks = 0, cycles = 0;

  cra_mem_model mem (.addr(pc), .byte0(mb0), .byte1(mb1), .byte2(mb2));
  cra_core DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dec_valid(dec_valid),
    .dec_opcode(dec_opcode), .dec_byte2(dec_byte2), .dec_byte3(dec_byte3),
    .pc_advance(pc_advance), .dec_done(dec_done), .dec_mode(dec_mode), .dec_len(dec_len),
    .dec_ea(dec_ea), .dec_acc_b(dec_acc_b), .alu_valid(alu_valid), .alu_op(alu_op),
    .alu_sel_b(alu_sel_b), .alu_operand(alu_operand), .stk_push(stk_push),
    .stk_pull(stk_pull), .stk_addr(stk_addr), .irq_req(irq_req), .instr_end(instr_end),
    .irq_take(irq_take), .ccr_out(ccr_out));

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Hang guard: counts as a mismatch
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      err_count++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // Each access starts on a fresh edge so strobes never collide
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdchk(input string n, input logic [2:0] a, input logic [15:0] e);
    rd(a, rv);
    chk(n, rv, e);
  endtask : rdchk

  task automatic alu(input cra_alu_e op, input logic sb, input logic [7:0] opnd);
    @(posedge clock);
    alu_valid   <= 1'b1;
    alu_op      <= op;
    alu_sel_b   <= sb;
    alu_operand <= opnd;
    @(posedge clock);
    alu_valid   <= 1'b0;
  endtask : alu

  task automatic irq_end(input logic exp);
    @(posedge clock);
    irq_req   <= 1'b1;
    instr_end <= 1'b1;
    @(posedge clock);
    instr_end <= 1'b0;
    #1 chk("irq take", {15'h0000, irq_take}, {15'h0000, exp});
    @(posedge clock);
    #1 chk("irq take low", {15'h0000, irq_take}, 16'h0000);
  endtask : irq_end

  // Scenarios
  task automatic t_reset();
    @(posedge clock);
    #1 chk("ccr out", {8'h00, ccr_out}, 16'h00D0);
    chk("reset mode", {9'h000, dec_mode}, 16'h0020);
    rdchk("ccr", REG_CONDITION_CODE, 16'h00D0);
    @(posedge clock);
    #1 chk("rdata idle", reg_rdata, 16'h0000);
    wr(3'h7, 16'hFFFF);
    rdchk("unmapped", 3'h7, 16'h0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_decode();
    wr(REG_INDEX_REGISTER, 16'h10FF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      pc_advance <= 1'b0;
      dec_valid  <= 1'b1;
      dec_opcode <= mb0;
      dec_byte2  <= mb1;
      dec_byte3  <= mb2;
      @(posedge clock);
      dec_valid  <= 1'b0;
      #1 chk("done", {15'h0000, dec_done}, 16'h0001);
      chk("mode", {9'h000, dec_mode}, {9'h000, EXP_MODE[i]});
      chk("len", {14'h0000, dec_len}, {14'h0000, EXP_LEN[i]});
      if (i != 4 && i != 5) chk("ea", dec_ea, EXP_EA[i]);
      chk("acc b", {15'h0000, dec_acc_b}, {15'h0000, EXP_ACCB[i]});
      @(posedge clock);
      pc_advance <= 1'b1;
      pc = pc + {14'h0000, EXP_LEN[i]};
      #1 chk("done low", {15'h0000, dec_done}, 16'h0000);
    end
    @(posedge clock);
    pc_advance <= 1'b0;
    rdchk("pc", REG_PROGRAM_COUNTER, 16'h0010);
    rdchk("index kept", REG_INDEX_REGISTER, 16'h10FF);
    $display("test decode done");
  endtask : t_decode

  // Wrap to zero sets Z, C and H; the load sets N, keeps C and H; subtract sets V, clears C
  task automatic t_alu();
    wr(REG_ACCUMULATOR_A, 16'h00FF);
    alu(ALU_ADD, 1'b0, 8'h01);
    rdchk("acc a", REG_ACCUMULATOR_A, 16'h0000);
    rdchk("ccr add", REG_CONDITION_CODE, 16'h00F5);
    alu(ALU_LD, 1'b1, 8'h80);
    rdchk("acc b", REG_ACCUMULATOR_B, 16'h0080);
    rdchk("ccr load", REG_CONDITION_CODE, 16'h00F9);
    wr(REG_ACCUMULATOR_A, 16'h0080);
    alu(ALU_SUB, 1'b0, 8'h01);
    rdchk("acc a sub", REG_ACCUMULATOR_A, 16'h007F);
    rdchk("ccr sub", REG_CONDITION_CODE, 16'h00F2);
    $display("test alu done");
  endtask : t_alu

  task automatic t_stack();
    wr(REG_STACK_POINTER, 16'h0100);
    @(posedge clock);
    stk_push <= 1'b1;
    @(posedge clock);
    stk_push <= 1'b0;
    #1 chk("push addr", stk_addr, 16'h0100);
    rdchk("sp push", REG_STACK_POINTER, 16'h00FF);
    @(posedge clock);
    stk_pull <= 1'b1;
    @(posedge clock);
    stk_pull <= 1'b0;
    #1 chk("pull addr", stk_addr, 16'h0100);
    rdchk("sp pull", REG_STACK_POINTER, 16'h0100);
    $display("test stack done");
  endtask : t_stack

  // Masked first, then unmasked; acceptance must set the mask again
  task automatic t_irq();
    irq_end(1'b0);
    wr(REG_CONDITION_CODE, 16'h0000);
    irq_end(1'b1);
    rdchk("ccr irq", REG_CONDITION_CODE, 16'h00D0);
    @(posedge clock);
    irq_req <= 1'b0;
    rd(REG_CYCLE_COUNT, cnt0);
    repeat (8) @(posedge clock);
    rd(REG_CYCLE_COUNT, rv);
    chk("cycles", rv - cnt0, 16'h000A);
    $display("test irq and cycles done");
  endtask : t_irq

  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_decode();
    t_alu();
    t_stack();
    t_irq();
    stop_test();
  end
endmodule : cra_core_bench
